// >>> hdl/udh_apb.sv
// apb slave holding the dma configuration registers
`timescale 1ns/1ps
`default_nettype none
module udh_apb
  import udh_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // register contents
  output logic ack_only_select,
  output logic [UDH_DMACFG_W-1:0] dma_config_reg,
  output logic [15:0] dma_byte_count_reg,
  // block state and hardware clear of the enable
  input wire logic [31:0] status_in,
  input wire logic [15:0] remain_in,
  input wire logic hw_stop
);
  logic acc;
  logic wr;
  logic hit;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign hit = paddr == UDH_HWCFG_OFS || paddr == UDH_DMACFG_OFS ||
    paddr == UDH_COUNT_OFS || paddr == UDH_STATUS_OFS || paddr == UDH_REMAIN_OFS;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_only_select <= 1'b0;
    else if (wr && paddr == UDH_HWCFG_OFS)
      ack_only_select <= pwdata[UDH_ACKONLY_BIT];
  end
  // a software write wins; a hardware stop only clears the enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dma_config_reg <= '0;
    else if (wr && paddr == UDH_DMACFG_OFS)
      dma_config_reg <= pwdata[UDH_DMACFG_W-1:0];
    else if (hw_stop)
      dma_config_reg[UDH_DMA_ENABLE_BIT_BIT] <= 1'b0;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dma_byte_count_reg <= UDH_COUNT_RST;
    else if (wr && paddr == UDH_COUNT_OFS)
      dma_byte_count_reg <= pwdata[15:0];
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= '0;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          UDH_HWCFG_OFS: prdata <= {31'h0, ack_only_select};
          UDH_DMACFG_OFS: prdata <= {{(32-UDH_DMACFG_W){1'b0}}, dma_config_reg};
          UDH_COUNT_OFS: prdata <= {16'h0, dma_byte_count_reg};
          UDH_STATUS_OFS: prdata <= status_in;
          UDH_REMAIN_OFS: prdata <= {16'h0, remain_in};
          default: prdata <= '0;
        endcase
      end
    end
  end
endmodule // udh_apb
`default_nettype wire

// >>> hdl/udh_pkg.sv
// constants and types of the usb device dma handshake block
package udh_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] UDH_HWCFG_OFS = 8'h00;
  localparam logic [7:0] UDH_DMACFG_OFS = 8'h04;
  localparam logic [7:0] UDH_COUNT_OFS = 8'h08;
  localparam logic [7:0] UDH_STATUS_OFS = 8'h0C;
  localparam logic [7:0] UDH_REMAIN_OFS = 8'h10;
  // hardware config fields
  localparam int UDH_ACKONLY_BIT = 0;
  // dma config fields
  localparam int UDH_EPIDX_LSB = 0;
  localparam int UDH_EPIDX_W = 4;
  localparam int UDH_DMA_ENABLE_BIT_BIT = 4;
  localparam int UDH_COUNTER_TERMINATE_ENABLE_BIT = 5;
  localparam int UDH_SHORT_PACKET_TERMINATE_ENABLE_BIT = 6;
  localparam int UDH_BURST_BIT = 7;
  localparam int UDH_ISO_BIT = 8;
  localparam int UDH_DMACFG_W = 9;
  localparam logic [15:0] UDH_COUNT_RST = 16'h0000;
  // bytes per bus word and per burst
  localparam logic [15:0] UDH_WORD_BYTES = 16'h0002;
  localparam int UDH_BURST_BYTES = 16;
  // end reasons shown in status
  typedef enum logic [2:0]
  {
    UDH_END_NONE = 3'b000,
    UDH_END_EXT = 3'b001,
    UDH_END_COUNT = 3'b010,
    UDH_END_SHORT = 3'b011,
    UDH_END_DISABLE = 3'b100,
    UDH_END_EOP = 3'b101
  } udh_end_t;
  typedef enum logic [1:0]
  {
    UDH_IDLE = 2'b00,
    UDH_REQ = 2'b01,
    UDH_XFER = 2'b10,
    UDH_GAP = 2'b11
  } udh_state_t;
endpackage : udh_pkg

// >>> hdl/udh_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module udh_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // udh_sync
`default_nettype wire

// >>> hdl/udh_top.sv
// dma request, strobe and termination logic of the usb device controller
// What this block does
// - raise dma request while the selected out endpoint fifo has data, or in endpoint fifo has room
// - classic mode: ack plus read strobe drives next fifo word onto bus
// - drop request during each word in both modes; gap state after each single-cycle word and after last word in burst
// - stop driving the data bus once ack is released
// - setting ack-only select bit enters ack-only mode
// - ack-only mode: ack is the data strobe, read/write strobes ignored
// - bulk ends on external end, counter, short out packet, or disable
// - external end on out endpoint: stop, flush active buffer only
// - external end on in endpoint: stop, send packet at next in token
// - 16-bit byte count copied into internal counter when enable sets
// - counter completion with counter-terminate set ends and halts dma
// - short out packet halts dma only after its bytes are moved
// - bulk in with short-packet end: counter zero mid-buffer terminates
// - clearing the enable stops the transfer and raises no interrupt
// - iso ends on external end, counter, end-of-packet, or disable
// - ack routes access to the dma endpoint index, not the i/o endpoint
// - direction follows endpoint direction bit: out reads, in writes
// - single-cycle and bursts of up to 16 bytes supported
// - clearing ack-only select gives request/ack mode with strobes
`timescale 1ns/1ps
`default_nettype none
module udh_top
  import udh_pkg::*;
#(
  parameter int BURST_BYTES = UDH_BURST_BYTES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  // apb register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // dma pins, all active high
  output logic DMA_REQUEST_OUT,
  input wire logic DMA_ACK_IN,
  input wire logic TRANSFER_TERMINATE_IN,
  input wire logic RD_STROBE_IN,
  input wire logic WR_STROBE_IN,
  // shared data bus
  input wire logic [15:0] DATA_IN,
  output logic [15:0] DATA_OUT,
  output logic DATA_OE,
  // endpoint side
  input wire logic [15:0] ENDPOINT_DIRECTION_BIT,
  input wire logic FIFO_HAS_DATA,
  input wire logic FIFO_HAS_ROOM,
  input wire logic [15:0] FIFO_RDATA,
  input wire logic SHORT_PACKET_IN,
  input wire logic EOP_IN,
  output logic [3:0] FIFO_EP_SEL,
  output logic FIFO_RD,
  output logic FIFO_WR,
  output logic [15:0] FIFO_WDATA,
  output logic FIFO_FLUSH_ACTIVE,
  output logic FIFO_VALIDATE
);
  // refuse bursts under two or over sixteen bytes, or of an odd byte count
  if (BURST_BYTES < 2 || BURST_BYTES > UDH_BURST_BYTES || BURST_BYTES % 2 != 0)
  begin : g_bad_burst
    $error("udh_top: burst size unsupported");
  end
  localparam logic [3:0] BURST_WORDS = 4'(BURST_BYTES / 2 - 1);

  logic ack_only_select;
  logic [UDH_DMACFG_W-1:0] cfg;
  logic [15:0] dma_byte_count_reg;
  logic [2:0] pins_s;
  logic ack_s;
  logic eot_s;
  logic rd_s;
  logic wr_s;
  logic [15:0] bus_s;
  logic dma_enable_bit;
  logic dir_in;
  logic strobe;
  logic strobe_d_r;
  logic word_end;
  logic stop;
  logic [15:0] remain_r;
  logic [3:0] burst_r;
  logic short_seen_r;
  logic en_d_r;
  logic done_r;
  udh_end_t end_r;
  udh_end_t end_nxt;
  udh_state_t state_r;
  udh_state_t state_nxt;
  logic [3:0] ep_idx;

  function automatic logic [15:0] dec_count(input logic [15:0] v);
    dec_count = (v > UDH_WORD_BYTES) ? 16'(v - UDH_WORD_BYTES) : 16'h0000;
  endfunction

  udh_apb u_apb (
    .clk(CLOCK),
    .rst_n(RST_N),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .ack_only_select(ack_only_select),
    .dma_config_reg(cfg),
    .dma_byte_count_reg(dma_byte_count_reg),
    .status_in({25'h0, end_r, done_r, dir_in, state_r}),
    .remain_in(remain_r),
    .hw_stop(stop)
  );

  // pins come from another timing domain
  udh_sync #(.W(3)) u_sync_ctl (
    .clk(CLOCK),
    .rst_n(RST_N),
    .d({DMA_ACK_IN, TRANSFER_TERMINATE_IN, RD_STROBE_IN}),
    .q(pins_s)
  );
  udh_sync #(.W(17)) u_sync_data (
    .clk(CLOCK),
    .rst_n(RST_N),
    .d({WR_STROBE_IN, DATA_IN}),
    .q({wr_s, bus_s})
  );
  assign ack_s = pins_s[2];
  assign eot_s = pins_s[1];
  assign rd_s = pins_s[0];

  assign dma_enable_bit = cfg[UDH_DMA_ENABLE_BIT_BIT];
  assign ep_idx = cfg[UDH_EPIDX_LSB +: UDH_EPIDX_W];
  assign dir_in = ENDPOINT_DIRECTION_BIT[ep_idx];

  // data strobe per mode
  always_comb
  begin
    if (ack_only_select)
      strobe = ack_s;
    else
      strobe = ack_s && (dir_in ? wr_s : rd_s);
  end
  // a word completes on strobe release, when the controller ends its cycle
  assign word_end = strobe_d_r && !strobe && state_r == UDH_XFER;

  // termination decode, in priority order
  always_comb
  begin
    end_nxt = UDH_END_NONE;
    if (state_r != UDH_IDLE)
    begin
      if (!dma_enable_bit)
        end_nxt = UDH_END_DISABLE;
      else if (eot_s)
        end_nxt = UDH_END_EXT;
      else if (cfg[UDH_COUNTER_TERMINATE_ENABLE_BIT] && word_end && dec_count(remain_r) == 16'h0000)
        end_nxt = UDH_END_COUNT;
      else if (!cfg[UDH_ISO_BIT] && cfg[UDH_SHORT_PACKET_TERMINATE_ENABLE_BIT] && !dir_in && short_seen_r &&
          !FIFO_HAS_DATA && !strobe)
        end_nxt = UDH_END_SHORT;
      else if (!cfg[UDH_ISO_BIT] && cfg[UDH_SHORT_PACKET_TERMINATE_ENABLE_BIT] && dir_in && word_end &&
          dec_count(remain_r) == 16'h0000)
        end_nxt = UDH_END_SHORT;
      else if (cfg[UDH_ISO_BIT] && EOP_IN)
        end_nxt = UDH_END_EOP;
    end
  end
  assign stop = end_nxt != UDH_END_NONE;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      UDH_IDLE:
        if (dma_enable_bit && !en_d_r)
          state_nxt = UDH_REQ;
      UDH_REQ:
        if (strobe)
          state_nxt = UDH_XFER;
      UDH_XFER:
        if (word_end)
          state_nxt = (!cfg[UDH_BURST_BIT] || burst_r == BURST_WORDS) ? UDH_GAP : UDH_REQ;
      UDH_GAP:
        if (!ack_s)
          state_nxt = UDH_REQ;
    endcase
    if (stop)
      state_nxt = UDH_IDLE;
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      state_r <= UDH_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      strobe_d_r <= 1'b0;
      en_d_r <= 1'b0;
    end
    else
    begin
      strobe_d_r <= strobe;
      en_d_r <= dma_enable_bit;
    end
  end

  // load on rising enable, step two bytes per word
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      remain_r <= UDH_COUNT_RST;
    else if (dma_enable_bit && !en_d_r)
      remain_r <= dma_byte_count_reg;
    else if (word_end)
      remain_r <= dec_count(remain_r);
  end

  // burst word counter, up to sixteen bytes
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      burst_r <= 4'h0;
    else if (state_r == UDH_GAP || state_r == UDH_IDLE)
      burst_r <= 4'h0;
    else if (word_end)
      burst_r <= burst_r + 4'h1;
  end

  // short packet seen: set wins over the restart clear
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      short_seen_r <= 1'b0;
    else if (SHORT_PACKET_IN)
      short_seen_r <= 1'b1;
    else if (dma_enable_bit && !en_d_r)
      short_seen_r <= 1'b0;
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      end_r <= UDH_END_NONE;
      done_r <= 1'b0;
    end
    else if (stop)
    begin
      end_r <= end_nxt;
      done_r <= 1'b1;
    end
    else if (dma_enable_bit && !en_d_r)
      done_r <= 1'b0;
  end

  // request: only in request state with data or room, held off after an end
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      DMA_REQUEST_OUT <= 1'b0;
    else
      DMA_REQUEST_OUT <= state_nxt == UDH_REQ && !stop &&
        (dir_in ? FIFO_HAS_ROOM : FIFO_HAS_DATA);
  end

  // bus drive; output enable follows synchronised ack, so it lags pin by ~3 cycles
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      DATA_OUT <= 16'h0000;
      DATA_OE <= 1'b0;
    end
    else
    begin
      DATA_OE <= strobe && !dir_in && ack_s;
      if (strobe && !strobe_d_r && !dir_in)
        DATA_OUT <= FIFO_RDATA;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      FIFO_EP_SEL <= 4'h0;
      FIFO_RD <= 1'b0;
      FIFO_WR <= 1'b0;
      FIFO_WDATA <= 16'h0000;
      FIFO_FLUSH_ACTIVE <= 1'b0;
      FIFO_VALIDATE <= 1'b0;
    end
    else
    begin
      FIFO_EP_SEL <= ep_idx;
      FIFO_RD <= word_end && !dir_in;
      FIFO_WR <= word_end && dir_in;
      if (strobe && dir_in)
        FIFO_WDATA <= bus_s;
      FIFO_FLUSH_ACTIVE <= end_nxt == UDH_END_EXT && !dir_in;
      FIFO_VALIDATE <= stop && dir_in && end_nxt != UDH_END_DISABLE;
    end
  end
endmodule // udh_top
`default_nettype wire

// >>> test/udh_dmac.sv
// fly-by dma controller model facing the block
`timescale 1ns/1ps
`default_nettype none
module udh_dmac (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control from bench
  input wire logic go,
  input wire logic dir_in,
  input wire logic ack_only,
  // dma pins
  input wire logic req,
  output logic ack,
  output logic rd,
  output logic wr,
  output logic [15:0] data,
  // bytes moved, two per word
  output logic [15:0] moved
);
  logic [2:0] cnt_r;
  // strobes held 5 cycles, gap 5: both clear the block's synchronisers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack <= 1'b0;
      cnt_r <= 3'h0;
      moved <= 16'h0000;
    end
    else if (cnt_r != 3'h0)
      cnt_r <= cnt_r - 3'h1;
    else if (ack)
    begin
      ack <= 1'b0;
      cnt_r <= 3'h4;
      moved <= moved + 16'h0002;
    end
    else if (go && req)
    begin
      ack <= 1'b1;
      cnt_r <= 3'h4;
    end
  end
  assign rd = ack && !dir_in && !ack_only;
  assign wr = ack && dir_in && !ack_only;
  // released bus shows the inverse, never a stale word
  assign data = ack ? 16'hA5C3 : 16'h5A3C;
endmodule // udh_dmac
`default_nettype wire

// >>> test/udh_top_asserts.sv
// port checker for the dma handshake block
`timescale 1ns/1ps
`default_nettype none
module udh_top_asserts (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // dma pins
  input wire logic DMA_REQUEST_OUT,
  input wire logic DMA_ACK_IN,
  input wire logic DATA_OE,
  // endpoint side
  input wire logic [15:0] ENDPOINT_DIRECTION_BIT,
  input wire logic [3:0] FIFO_EP_SEL,
  input wire logic FIFO_RD,
  input wire logic FIFO_WR,
  input wire logic FIFO_FLUSH_ACTIVE,
  input wire logic FIFO_VALIDATE
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  logic in_ep;
  assign in_ep = ENDPOINT_DIRECTION_BIT[FIFO_EP_SEL];
  a_ready_access: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && !PENABLE))
    else $error("ready outside access");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_oe_out_only: assert property (DATA_OE |-> !in_ep)
    else $error("bus driven for in endpoint");
  a_oe_release: assert property ($fell(DMA_ACK_IN) |-> ##[1:5] !DATA_OE)
    else $error("bus still driven");
  a_req_drop: assert property ($rose(DATA_OE) |-> ##[0:2] !DMA_REQUEST_OUT)
    else $error("request held during word");
  a_read_dir: assert property (FIFO_RD |-> !in_ep && !FIFO_WR)
    else $error("read on in endpoint");
  a_write_dir: assert property (FIFO_WR |-> in_ep)
    else $error("write on out endpoint");
  a_word_done: assert property (FIFO_RD || FIFO_WR |-> !DMA_ACK_IN && !$past(DMA_ACK_IN, 2))
    else $error("word done while ack high");
  a_flush_out: assert property (FIFO_FLUSH_ACTIVE |-> !in_ep ##1 !FIFO_FLUSH_ACTIVE)
    else $error("bad flush");
  a_valid_in: assert property (FIFO_VALIDATE |-> in_ep ##1 !FIFO_VALIDATE)
    else $error("bad validate");
  a_quiet_end: assert property ($rose(FIFO_FLUSH_ACTIVE || FIFO_VALIDATE) |=> !DMA_REQUEST_OUT[*4])
    else $error("request after end");
endmodule // udh_top_asserts
bind udh_top udh_top_asserts i_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .DMA_REQUEST_OUT(DMA_REQUEST_OUT), .DMA_ACK_IN(DMA_ACK_IN),
  .DATA_OE(DATA_OE), .ENDPOINT_DIRECTION_BIT(ENDPOINT_DIRECTION_BIT),
  .FIFO_EP_SEL(FIFO_EP_SEL), .FIFO_RD(FIFO_RD), .FIFO_WR(FIFO_WR),
  .FIFO_FLUSH_ACTIVE(FIFO_FLUSH_ACTIVE), .FIFO_VALIDATE(FIFO_VALIDATE)
);
`default_nettype wire

// >>> test/udh_top_bench.sv
// self-checking bench of the dma handshake block
`timescale 1ns/1ps
`default_nettype none
module udh_top_bench
  import udh_pkg::*;
;
  logic clk, rst_n, psel, pen, pw, term, go, hasd, ao, err, eop, spk;
  logic [7:0] pa;
  logic [31:0] pwd;
  logic [15:0] dirs;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, req, ack, rds, wrs, oe, frd, fwr, fl, val;
  wire logic [15:0] din, dout, fwd, moved;
  wire logic [3:0] eps;
  int bad_count, checks_done, cyc, nrd, nwr, nfl, nval;

  udh_top i_dut (
    .CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pw), .PADDR(pa),
    .PWDATA(pwd), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DMA_REQUEST_OUT(req), .DMA_ACK_IN(ack), .TRANSFER_TERMINATE_IN(term),
    .RD_STROBE_IN(rds), .WR_STROBE_IN(wrs), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe),
    .ENDPOINT_DIRECTION_BIT(dirs), .FIFO_HAS_DATA(hasd), .FIFO_HAS_ROOM(1'b1),
    .FIFO_RDATA(16'h1234), .SHORT_PACKET_IN(spk), .EOP_IN(eop), .FIFO_EP_SEL(eps),
    .FIFO_RD(frd), .FIFO_WR(fwr), .FIFO_WDATA(fwd), .FIFO_FLUSH_ACTIVE(fl),
    .FIFO_VALIDATE(val)
  );
  udh_dmac i_dmac (
    .clk(clk), .rst_n(rst_n), .go(go), .dir_in(dirs[eps]), .ack_only(ao),
    .req(req), .ack(ack), .rd(rds), .wr(wrs), .data(din), .moved(moved)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, s, e);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (frd === 1'b1) nrd++;
    if (fwr === 1'b1) nwr++;
    if (fl === 1'b1) nfl++;
    if (val === 1'b1) nval++;
    if (oe === 1'b1) chk(dout, 32'h1234);
    if (fwr === 1'b1) chk(fwd, 32'hA5C3);
    if (cyc > 20000)
    begin
      bad_count++;
      summarize();
    end
  end

  // one idle cycle after each transfer keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel <= 1'b1;
    pen <= 1'b0;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_end(output logic [31:0] r);
    do
      apb(1'b0, UDH_STATUS_OFS, 32'h0, r);
    while (r[3] !== 1'b1);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    apb(1'b0, 8'h20, 32'h0, r);
    chk(err, 1'b1);
    chk(r, 32'h0);
    apb(1'b0, UDH_HWCFG_OFS, 32'h0, r);
    chk(r[0], 1'b0);
    apb(1'b1, UDH_COUNT_OFS, 32'hBEEE, r);
    apb(1'b0, UDH_COUNT_OFS, 32'h0, r);
    chk(r[15:0], 16'hBEEE);
  endtask

  task automatic t_out_count();
    logic [31:0] r;
    nrd = 0;
    apb(1'b1, UDH_COUNT_OFS, 32'h6, r);
    apb(1'b1, UDH_DMACFG_OFS, 32'h31, r);
    repeat (8) @(posedge clk);
    chk(req, 1'b1);
    apb(1'b0, UDH_REMAIN_OFS, 32'h0, r);
    chk(r[15:0], 16'h6);
    go <= 1'b1;
    wait_end(r);
    chk(r[6:4], UDH_END_COUNT);
    chk(nrd, 3);
    chk(moved, 16'h6);
    repeat (8)
    begin
      @(posedge clk);
      chk(req, 1'b0);
    end
    go <= 1'b0;
  endtask

  task automatic t_out_ext();
    logic [31:0] r;
    nrd = 0;
    nfl = 0;
    apb(1'b1, UDH_DMACFG_OFS, 32'h91, r);
    go <= 1'b1;
    wait (nrd == 1);
    term <= 1'b1;
    wait_end(r);
    term <= 1'b0;
    go <= 1'b0;
    chk(r[6:4], UDH_END_EXT);
    chk(nfl, 1);
  endtask

  task automatic t_in_ext();
    logic [31:0] r;
    nwr = 0;
    nval = 0;
    apb(1'b1, UDH_HWCFG_OFS, 32'h1, r);
    ao <= 1'b1;
    apb(1'b1, UDH_DMACFG_OFS, 32'h12, r);
    go <= 1'b1;
    wait (nwr == 2);
    term <= 1'b1;
    wait_end(r);
    term <= 1'b0;
    go <= 1'b0;
    chk(r[6:4], UDH_END_EXT);
    chk(nval, 1);
    apb(1'b1, UDH_HWCFG_OFS, 32'h0, r);
    ao <= 1'b0;
  endtask

  task automatic t_disable();
    logic [31:0] r;
    nfl = 0;
    nval = 0;
    apb(1'b1, UDH_DMACFG_OFS, 32'h11, r);
    repeat (8) @(posedge clk);
    chk(req, 1'b1);
    apb(1'b1, UDH_DMACFG_OFS, 32'h01, r);
    apb(1'b0, UDH_STATUS_OFS, 32'h0, r);
    chk(r[6:4], UDH_END_DISABLE);
    chk(nfl + nval, 0);
    chk(req, 1'b0);
  endtask

  // iso out ended by end-of-packet, the preferred way
  task automatic t_iso_eop();
    logic [31:0] r;
    apb(1'b1, UDH_DMACFG_OFS, 32'h111, r);
    repeat (4) @(posedge clk);
    eop <= 1'b1;
    @(posedge clk);
    eop <= 1'b0;
    wait_end(r);
    chk(r[6:4], UDH_END_EOP);
  endtask

  // short out packet ends only once the fifo has drained
  task automatic t_out_short();
    logic [31:0] r;
    apb(1'b1, UDH_DMACFG_OFS, 32'h51, r);
    spk <= 1'b1;
    @(posedge clk);
    spk <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, UDH_STATUS_OFS, 32'h0, r);
    chk(r[3], 1'b0);
    hasd <= 1'b0;
    wait_end(r);
    hasd <= 1'b1;
    chk(r[6:4], UDH_END_SHORT);
  endtask

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pw = 1'b0;
    pa = 8'h00;
    pwd = 32'h0;
    term = 1'b0;
    go = 1'b0;
    ao = 1'b0;
    hasd = 1'b1;
    eop = 1'b0;
    spk = 1'b0;
    dirs = 16'h0004;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(req, 1'b0);
    t_regs();
    t_out_count();
    t_out_ext();
    t_in_ext();
    t_disable();
    t_iso_eop();
    t_out_short();
    summarize();
  end
endmodule // udh_top_bench
`default_nettype wire
